// *** hdl/ngse_pkg.sv ***
// Functional notes
// - Phases run: cmd0, addr0, cmd1, addr1, cmd2, wait0, data, cmd3, wait1.
// - Opening command always sent, opcode from first opcode field.
// - First address sent only if its column or row count nonzero.
// - Second command sent only when its enable bit is set.
// - Second address sent only if its column or row count nonzero.
// - Third command sent only when its enable bit is set.
// - First wait holds the sequence until flash ready, then continues.
// - Data phase moves data-size bytes; 18 reads, 19 writes.
// - Trailing command sent when enabled, opcode from control register.
// - Final wait holds completion until flash returns ready.
// - Immediate bit starts opcodes 0x70, 0x71, 0x72, 0x78 or 0xE1 even while previous command busy.
// - Immediate mode reads only when started over a busy engine, into the single data register.
// - A programmable delay from one step timer, with three step-delay lengths, follows every phase.
// - Reset instruction sends 0xFF as a command-only sequence.
// - Writing the instruction word starts execution, no start bit.
// - Decode selects data input and hands sequence to the sequencer.
// - With interrupts enabled, a pulse is raised at sequence end.
// - Unused input-select fields are forced to zero; unused data-destination too, except in immediate mode.
// - Ready wait watches ready/busy line or polls status command.
package ngse_pkg;

  localparam logic [5:0] NGSE_SEQ_RESET     = 6'h00;
  localparam logic [5:0] NGSE_SEQ_GEN_READ  = 6'h12;
  localparam logic [5:0] NGSE_SEQ_GEN_WRITE = 6'h13;
  localparam logic [7:0] NGSE_OP_RESET      = 8'hFF;
  localparam logic [7:0] NGSE_OP_STATUS     = 8'h70;
  localparam logic [7:0] NGSE_STATUS_RDY    = 8'h40;
  localparam int         NGSE_CNT_W         = 16;

  // Instruction word written by software
  typedef struct packed {
    logic [7:0] cmd2;        // third opcode
    logic [7:0] cmd1;        // second opcode
    logic [7:0] cmd0;        // first opcode
    logic       data_sel;    // 1: single data register sink
    logic       input_sel;   // FIFO input module select
    logic [5:0] seq_num;     // sequence_number_field
  } ngse_instr_s;

  // generic_sequence_control fields
  typedef struct packed {
    logic [7:0] cmd3;                      // last opcode
    logic [2:0] first_column_byte_count;
    logic [2:0] first_row_byte_count;
    logic [2:0] second_column_byte_count;
    logic [2:0] second_row_byte_count;
    logic       second_opcode_enable;
    logic       third_opcode_enable;
    logic       last_opcode_enable;
    logic       delay_en;                  // wait enable
    logic       delay_sel;                 // 0: first, 1: final wait
    logic       data_en;
    logic       immediate_execute;
    logic       poll_status;               // 1: poll status, 0: line
  } ngse_ctrl_s;

  // One cycle on the flash bus
  typedef struct packed {
    logic       valid;
    logic       is_cmd;      // 1: command latch, 0: address latch
    logic [7:0] byte_v;
  } ngse_bus_s;

  typedef enum logic [3:0] {
    NGSE_IDLE  = 4'b0000,
    NGSE_CMD0  = 4'b0001,
    NGSE_ADR0  = 4'b0010,
    NGSE_CMD1  = 4'b0011,
    NGSE_ADR1  = 4'b0100,
    NGSE_CMD2  = 4'b0101,
    NGSE_WAIT0 = 4'b0110,
    NGSE_DATA  = 4'b0111,
    NGSE_CMD3  = 4'b1000,
    NGSE_WAIT1 = 4'b1001,
    NGSE_DLY   = 4'b1010,
    NGSE_POLL  = 4'b1011
  } ngse_state_e;

endpackage

// *** hdl/ngse_step_timer.sv ***
// Down counter for the programmable gap after each phase
module ngse_step_timer
  import ngse_pkg::*;
#(
  parameter int W = NGSE_CNT_W
)(
  input  wire logic         i_clk_sys,  // System clock
  input  wire logic         i_reset_n,  // Async reset, active low
  input  wire logic         i_load,     // Start a delay
  input  wire logic [W-1:0] i_cycles,   // Delay length in cycles
  output logic              o_done      // Level, high when idle
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } ngse_tmr_s;

  ngse_tmr_s st_r;
  ngse_tmr_s st_nxt;

  // Load wins over counting; zero means no gap
  always_comb
  begin
    st_nxt = st_r;
    if (i_load)
      st_nxt.cnt = i_cycles;
    else if (st_r.cnt != '0)
      st_nxt.cnt = st_r.cnt - 1'b1;
  end

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign o_done = (st_r.cnt == '0) && !i_load;
endmodule

// *** hdl/ngse_engine.sv ***
// Generic NAND command-sequence engine with instruction dispatch
module ngse_engine
  import ngse_pkg::*;
#(
  parameter int W = NGSE_CNT_W
)(
  input  wire logic              i_clk_sys,       // System clock
  input  wire logic              i_reset_n,       // Async reset, active low
  input  wire logic              i_instr_wr,      // Instruction write strobe
  input  wire ngse_instr_s       i_instr,         // Instruction word
  input  wire ngse_ctrl_s        i_gen_ctrl,      // Generic control
  input  wire logic [15:0]       i_first_column_address,  // First_column_address
  input  wire logic [23:0]       i_first_row_address,     // First_row_address
  input  wire logic [15:0]       i_second_column_address, // Second_column_address
  input  wire logic [23:0]       i_second_row_address,    // Second_row_address
  input  wire logic [W-1:0]      i_data_size,     // Data block length
  input  wire logic [W-1:0]      i_step_delay_0,  // Gap after cmd phases
  input  wire logic [W-1:0]      i_step_delay_1,  // Gap after addr phases
  input  wire logic [W-1:0]      i_step_delay_2,  // Gap after data/wait
  input  wire logic              i_irq_en,        // Interrupt enable
  input  wire logic              i_ready_busy_line, // Flash ready, high
  input  wire logic              i_bus_ack,       // Bus cycle accepted
  input  wire logic              i_data_ack,      // Data byte moved
  input  wire logic [7:0]        i_rd_byte,       // Byte read from flash
  output ngse_bus_s              o_bus,           // Command/address cycle
  output logic                   o_data_req,      // Data byte request
  output logic                   o_data_write,    // 1: write to flash
  output logic                   o_data_to_reg,   // Sink is data register
  output logic                   o_input_sel,     // FIFO input select
  output logic [7:0]             o_data_reg,      // Single data register
  output logic                   o_busy,          // Sequence running
  output logic                   o_done,          // Completion pulse
  output logic                   o_irq,           // Interrupt pulse
  output logic                   o_refused        // Instruction dropped
);

  typedef struct packed {
    ngse_state_e  state;
    ngse_state_e  after;       // phase to resume after the gap
    ngse_instr_s  instr;
    ngse_ctrl_s   ctrl;
    logic [2:0]   idx;         // address byte index
    logic [W-1:0] cnt;         // data byte count
    logic         poll_cmd;    // status command already sent
    logic [7:0]   data_reg;
    logic         done;
    logic         irq;
    logic         refused;
  } ngse_eng_s;

  ngse_eng_s   st_r;
  ngse_eng_s   st_nxt;
  logic        tmr_load;
  logic [W-1:0] tmr_cycles;
  logic        tmr_done;
  logic        accept;
  logic        busy_ok;

  // Opcodes allowed to start while a sequence is running
  function automatic logic ngse_busy_ok(input logic [7:0] op);
    ngse_busy_ok = (op == 8'h70) || (op == 8'h71) || (op == 8'h72) ||
                   (op == 8'h78) || (op == 8'hE1);
  endfunction

  // Next phase after the one given, skipping disabled phases
  function automatic ngse_state_e ngse_next(input ngse_state_e s,
                                            input ngse_ctrl_s c,
                                            input logic [5:0] seq);
    logic gen;
    gen = (seq == NGSE_SEQ_GEN_READ) || (seq == NGSE_SEQ_GEN_WRITE);
    ngse_next = NGSE_IDLE;
    if (gen)
    begin
      // Fall through the fixed order from s onward
      if (s == NGSE_CMD0 && ((c.first_column_byte_count != 3'h0) ||
          (c.first_row_byte_count != 3'h0)))
        ngse_next = NGSE_ADR0;
      else if ((s <= NGSE_ADR0) && c.second_opcode_enable)
        ngse_next = NGSE_CMD1;
      else if ((s <= NGSE_CMD1) &&
               ((c.second_column_byte_count != 3'h0) ||
                (c.second_row_byte_count != 3'h0)))
        ngse_next = NGSE_ADR1;
      else if ((s <= NGSE_ADR1) && c.third_opcode_enable)
        ngse_next = NGSE_CMD2;
      else if ((s <= NGSE_CMD2) && c.delay_en && !c.delay_sel)
        ngse_next = NGSE_WAIT0;
      else if ((s <= NGSE_WAIT0) && c.data_en)
        ngse_next = NGSE_DATA;
      else if ((s <= NGSE_DATA) && c.last_opcode_enable)
        ngse_next = NGSE_CMD3;
      else if ((s <= NGSE_CMD3) && c.delay_en && c.delay_sel)
        ngse_next = NGSE_WAIT1;
    end
  endfunction

  // Gap length per finished phase
  function automatic logic [W-1:0] ngse_gap(input ngse_state_e s,
                                            input logic [W-1:0] d0,
                                            input logic [W-1:0] d1,
                                            input logic [W-1:0] d2);
    case (s)
      NGSE_ADR0, NGSE_ADR1:              ngse_gap = d1;
      NGSE_DATA, NGSE_WAIT0, NGSE_WAIT1: ngse_gap = d2;
      default:                           ngse_gap = d0;
    endcase
  endfunction

  // Address byte: column bytes first, then row bytes
  function automatic logic [7:0] ngse_abyte(input logic [2:0] i,
                                            input logic [2:0] ncol,
                                            input logic [15:0] col,
                                            input logic [23:0] row);
    logic [2:0] r;
    r = i - ncol;
    if (i < ncol)
      ngse_abyte = (i == 3'h0) ? col[7:0] : col[15:8];
    else
      ngse_abyte = (r == 3'h0) ? row[7:0] :
                   (r == 3'h1) ? row[15:8] : row[23:16];
  endfunction

  assign busy_ok = ngse_busy_ok(i_instr.cmd0);
  // Immediate execution over a busy engine is read only; otherwise a busy engine refuses
  assign accept = i_instr_wr && ((st_r.state == NGSE_IDLE) ||
                  (busy_ok && i_gen_ctrl.immediate_execute &&
                   (i_instr.seq_num != NGSE_SEQ_GEN_WRITE)));

  // Sequencer next state
  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.done    = 1'b0;
    st_nxt.irq     = 1'b0;
    st_nxt.refused = 1'b0;
    tmr_load       = 1'b0;
    tmr_cycles     = '0;
    if (accept)
    begin
      // Decode and hand over; write starts the run at once
      st_nxt.instr = i_instr;
      st_nxt.ctrl  = i_gen_ctrl;
      if (!i_gen_ctrl.data_en ||
          ((i_instr.seq_num != NGSE_SEQ_GEN_READ) &&
           (i_instr.seq_num != NGSE_SEQ_GEN_WRITE)))
      begin
        st_nxt.instr.data_sel  = 1'b0;
        st_nxt.instr.input_sel = 1'b0;
      end
      if (i_gen_ctrl.immediate_execute)
        st_nxt.instr.data_sel = 1'b1;
      if (i_instr.seq_num == NGSE_SEQ_RESET)
        st_nxt.instr.cmd0 = NGSE_OP_RESET;
      st_nxt.state    = NGSE_CMD0;
      st_nxt.idx      = 3'h0;
      st_nxt.cnt      = '0;
      st_nxt.poll_cmd = 1'b0;
    end
    else
    begin
      st_nxt.refused = i_instr_wr;
      case (st_r.state)
        NGSE_IDLE:
          st_nxt.state = NGSE_IDLE;
        NGSE_CMD0, NGSE_CMD1, NGSE_CMD2, NGSE_CMD3:
          if (i_bus_ack)
          begin
            st_nxt.after = ngse_next(st_r.state, st_r.ctrl,
                                     st_r.instr.seq_num);
            st_nxt.state = NGSE_DLY;
            tmr_load     = 1'b1;
            tmr_cycles   = ngse_gap(st_r.state, i_step_delay_0,
                                    i_step_delay_1, i_step_delay_2);
          end
        NGSE_ADR0, NGSE_ADR1:
          if (i_bus_ack)
          begin
            if (st_r.idx + 3'h1 == o_addr_total(st_r))
            begin
              st_nxt.idx   = 3'h0;
              st_nxt.after = ngse_next(st_r.state, st_r.ctrl,
                                       st_r.instr.seq_num);
              st_nxt.state = NGSE_DLY;
              tmr_load     = 1'b1;
              tmr_cycles   = i_step_delay_1;
            end
            else
              st_nxt.idx = st_r.idx + 3'h1;
          end
        NGSE_WAIT0, NGSE_WAIT1:
          if (st_r.ctrl.poll_status)
            st_nxt.state = NGSE_POLL;
          else if (i_ready_busy_line)
          begin
            st_nxt.after = ngse_next(st_r.state, st_r.ctrl,
                                     st_r.instr.seq_num);
            st_nxt.state = NGSE_DLY;
            tmr_load     = 1'b1;
            tmr_cycles   = i_step_delay_2;
          end
        NGSE_POLL:
          if (!st_r.poll_cmd)
            st_nxt.poll_cmd = i_bus_ack;
          else if (i_data_ack && ((i_rd_byte & NGSE_STATUS_RDY) != 8'h00))
          begin
            st_nxt.poll_cmd = 1'b0;
            st_nxt.after    = ngse_next(st_r.after, st_r.ctrl,
                                        st_r.instr.seq_num);
            st_nxt.state    = NGSE_DLY;
            tmr_load        = 1'b1;
            tmr_cycles      = i_step_delay_2;
          end
        NGSE_DATA:
          if (i_data_ack)
          begin
            if (st_r.instr.seq_num == NGSE_SEQ_GEN_READ &&
                st_r.instr.data_sel)
              st_nxt.data_reg = i_rd_byte;
            st_nxt.cnt = st_r.cnt + 1'b1;
            if (st_r.cnt + 1'b1 == i_data_size)
            begin
              st_nxt.after = ngse_next(NGSE_DATA, st_r.ctrl,
                                       st_r.instr.seq_num);
              st_nxt.state = NGSE_DLY;
              tmr_load     = 1'b1;
              tmr_cycles   = i_step_delay_2;
            end
          end
        NGSE_DLY:
          if (tmr_done)
          begin
            st_nxt.state = st_r.after;
            if (st_r.after == NGSE_IDLE)
            begin
              st_nxt.done = 1'b1;
              st_nxt.irq  = i_irq_en;
            end
          end
        default:
          st_nxt.state = NGSE_IDLE;
      endcase
    end
  end

  // Byte count of the address phase in progress
  function automatic logic [2:0] o_addr_total(input ngse_eng_s s);
    if (s.state == NGSE_ADR0)
      o_addr_total = s.ctrl.first_column_byte_count +
                     s.ctrl.first_row_byte_count;
    else
      o_addr_total = s.ctrl.second_column_byte_count +
                     s.ctrl.second_row_byte_count;
  endfunction

  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      st_r       <= '0;
      st_r.state <= NGSE_IDLE;
      st_r.after <= NGSE_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  ngse_step_timer #(
    .W (W)
  ) u_timer (
    .i_clk_sys (i_clk_sys),
    .i_reset_n (i_reset_n),
    .i_load    (tmr_load),
    .i_cycles  (tmr_cycles),
    .o_done    (tmr_done)
  );

  // Bus cycle request for the current command or address phase
  always_comb
  begin
    o_bus = '0;
    case (st_r.state)
      NGSE_CMD0:
        o_bus = '{1'b1, 1'b1, st_r.instr.cmd0};
      NGSE_CMD1:
        o_bus = '{1'b1, 1'b1, st_r.instr.cmd1};
      NGSE_CMD2:
        o_bus = '{1'b1, 1'b1, st_r.instr.cmd2};
      NGSE_CMD3:
        o_bus = '{1'b1, 1'b1, st_r.ctrl.cmd3};
      NGSE_ADR0:
        o_bus = '{1'b1, 1'b0, ngse_abyte(st_r.idx,
                  st_r.ctrl.first_column_byte_count,
                  i_first_column_address, i_first_row_address)};
      NGSE_ADR1:
        o_bus = '{1'b1, 1'b0, ngse_abyte(st_r.idx,
                  st_r.ctrl.second_column_byte_count,
                  i_second_column_address,
                  i_second_row_address)};
      NGSE_POLL:
        if (!st_r.poll_cmd)
          o_bus = '{1'b1, 1'b1, NGSE_OP_STATUS};
      default:
        o_bus = '0;
    endcase
  end

  // Data handshake and status outputs
  assign o_data_req    = (st_r.state == NGSE_DATA) ||
                         ((st_r.state == NGSE_POLL) && st_r.poll_cmd);
  assign o_data_write  = (st_r.instr.seq_num == NGSE_SEQ_GEN_WRITE);
  assign o_data_to_reg = st_r.instr.data_sel;
  assign o_input_sel   = st_r.instr.input_sel;
  assign o_data_reg    = st_r.data_reg;
  assign o_busy        = (st_r.state != NGSE_IDLE);
  assign o_done        = st_r.done;
  assign o_irq         = st_r.irq;
  assign o_refused     = st_r.refused;

  // Command phase ends only on an accepted bus cycle
  AST_CMD_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_r.state == NGSE_CMD0 && !i_bus_ack && !accept) |=>
      st_r.state == NGSE_CMD0)
    else $error("first command left without ack");
  AST_RESET_OP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (accept && i_instr.seq_num == NGSE_SEQ_RESET) |=>
      o_bus.byte_v == 8'hFF && o_bus.is_cmd)
    else $error("reset instruction sent wrong opcode");
  AST_START: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    accept |=> o_busy && st_r.state == NGSE_CMD0)
    else $error("instruction write did not start sequence");
  AST_WAIT_RDY: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_r.state == NGSE_WAIT0 && !i_ready_busy_line &&
     !st_r.ctrl.poll_status && !accept) |=> st_r.state == NGSE_WAIT0)
    else $error("wait phase left while flash busy");
  AST_IRQ: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    o_irq |-> o_done && $past(i_irq_en))
    else $error("interrupt without completion");
  AST_DONE_IDLE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    $rose(o_done) |-> $past(st_r.state) == NGSE_DLY && !o_busy)
    else $error("completion before last delay");
  AST_DATA_END: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (st_r.state == NGSE_DATA && i_data_ack && !accept &&
     st_r.cnt + 1'b1 == i_data_size) |=> st_r.state == NGSE_DLY)
    else $error("data phase did not end at size");
  AST_IMM_READ: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
    (accept && o_busy) |-> i_instr.seq_num != NGSE_SEQ_GEN_WRITE)
    else $error("immediate write accepted");
endmodule

// *** test/ngse_flash_model.sv ***
// Behavioural flash: logs bus cycles, answers data, pulls busy
module ngse_flash_model
  import ngse_pkg::*;
#(
  parameter int BUSY_CYC = 8
)(
  input  wire logic      i_clk_sys,  // System clock
  input  wire logic      i_reset_n,  // Async reset, active low
  input  wire ngse_bus_s i_bus,      // Command/address cycle
  input  wire logic      i_data_req, // Data byte request
  input  wire logic      i_slow,     // Stretch every answer
  output logic           o_ack,      // Bus cycle taken
  output logic           o_data_ack, // Data byte moved
  output logic [7:0]     o_rd_byte,  // Read data
  output logic           o_ready     // Ready/busy line, high ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0]  log_q[$];
  logic [7:0]  seq_byte;
  int unsigned busy_cnt;
  int unsigned wait_cnt;
  int unsigned n_data;
  int unsigned n_stat;
  int unsigned id_len;
  logic [7:0]  last_cmd;
  logic        id_pend;

  assign o_ready = (busy_cnt == 0);
  // One answer at a time; idle read data toggles so stale bytes show
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      o_ack      <= 1'b0;
      o_data_ack <= 1'b0;
      o_rd_byte  <= 8'h00;
      seq_byte   <= 8'h5A;
      busy_cnt   <= 0;
      wait_cnt   <= 0;
      n_data     <= 0;
      n_stat     <= 0;
      id_len     <= 0;
      last_cmd   <= 8'h00;
      id_pend    <= 1'b0;
    end
    else
    begin
      o_ack      <= 1'b0;
      o_data_ack <= 1'b0;
      o_rd_byte  <= ~o_rd_byte;
      if (busy_cnt != 0)
        busy_cnt <= busy_cnt - 1;
      if ((i_bus.valid || i_data_req) && !o_ack && !o_data_ack)
      begin
        if (wait_cnt < (i_slow ? 3 : 0))
          wait_cnt <= wait_cnt + 1;
        else if (i_bus.valid)
        begin
          wait_cnt <= 0;
          o_ack    <= 1'b1;
          log_q.push_back({i_bus.is_cmd, i_bus.byte_v});
          // Status command must not restart the busy time it reports
          if (i_bus.is_cmd)
          begin
            last_cmd <= i_bus.byte_v;
            id_pend  <= (i_bus.byte_v == 8'h90);
            if (i_bus.byte_v != 8'h70)
              busy_cnt <= BUSY_CYC;
          end
          else if (id_pend)
          begin
            // Identify length follows the address byte
            id_pend <= 1'b0;
            id_len  <= (i_bus.byte_v == 8'h00) ? 5 :
                       (i_bus.byte_v == 8'h20) ? 4 : 0;
          end
        end
        else
        begin
          wait_cnt   <= 0;
          o_data_ack <= 1'b1;
          // Status mode answers ready in bit 6 and ends once ready shows
          o_rd_byte  <= (last_cmd == 8'h70) ? {1'b0, o_ready, 6'h00} :
                        seq_byte;
          seq_byte   <= seq_byte + 8'h01;
          n_data     <= n_data + 1;
          if (last_cmd == 8'h70)
          begin
            n_stat <= n_stat + 1;
            if (o_ready)
              last_cmd <= 8'h00;
          end
        end
      end
    end
  end
endmodule

// *** test/tb.sv ***
module tb;
  import ngse_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        instr_wr = 1'b0;
  logic        irq_en = 1'b0;
  logic        slow = 1'b0;
  logic [15:0] data_size = 16'h0003;
  logic [15:0] col0 = 16'h3412;
  logic [15:0] dly0 = 16'h0002;
  int          nd;
  ngse_instr_s instr = '0;
  ngse_ctrl_s  gen_ctrl = '0;
  ngse_bus_s   bus;
  logic        bus_ack, data_ack, ready, data_req, data_write;
  logic        data_to_reg, input_sel, busy, done, irq, refused;
  logic [7:0]  rd_byte, data_reg, base;
  logic        irq_seen, rdy, refd;
  int          errors = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  always #12.5 clk_sys = ~clk_sys;

  ngse_engine dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
    .i_instr_wr(instr_wr), .i_instr(instr), .i_gen_ctrl(gen_ctrl),
    .i_first_column_address(col0), .i_first_row_address(24'h786756),
    .i_second_column_address(16'hBC9A), .i_second_row_address(24'h000011),
    .i_data_size(data_size), .i_step_delay_0(dly0),
    .i_step_delay_1(16'h0003), .i_step_delay_2(16'h0004),
    .i_irq_en(irq_en), .i_ready_busy_line(ready), .i_bus_ack(bus_ack),
    .i_data_ack(data_ack), .i_rd_byte(rd_byte), .o_bus(bus),
    .o_data_req(data_req), .o_data_write(data_write),
    .o_data_to_reg(data_to_reg), .o_input_sel(input_sel),
    .o_data_reg(data_reg), .o_busy(busy), .o_done(done), .o_irq(irq),
    .o_refused(refused));

  ngse_flash_model #(.BUSY_CYC(40)) p (.i_clk_sys(clk_sys),
    .i_reset_n(reset_n),
    .i_bus(bus), .i_data_req(data_req), .i_slow(slow), .o_ack(bus_ack),
    .o_data_ack(data_ack), .o_rd_byte(rd_byte), .o_ready(ready));

  task automatic close_out();
    if (errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Write strobe for one cycle, then watch for a refusal pulse
  task automatic issue(input ngse_instr_s ins, input ngse_ctrl_s c);
    @(posedge clk_sys);
    instr    <= ins;
    gen_ctrl <= c;
    instr_wr <= 1'b1;
    @(posedge clk_sys);
    instr_wr <= 1'b0;
    #1 refd = refused;
    @(posedge clk_sys);
    #1 refd = refd | refused;
  endtask

  // Bounded wait for completion; interrupt pulses in the same cycle as done
  task automatic finish_seq();
    int n;
    irq_seen = 1'b0;
    for (n = 0; n < 3000; n++)
    begin
      @(posedge clk_sys);
      #1 irq_seen = irq_seen | irq;
      rdy = ready;
      if (done === 1'b1)
        break;
    end
    if (n == 3000)
      check("done", 16'h0001, 16'h0000);
    @(posedge clk_sys);
    #1 irq_seen = irq_seen | irq;
  endtask

  task automatic cmp_log(input logic [8:0] e[$]);
    check("log_size", 16'(e.size()), 16'(p.log_q.size()));
    foreach (e[i])
      if (i < p.log_q.size())
        check("log_byte", {7'h00, e[i]}, {7'h00, p.log_q[i]});
    p.log_q.delete();
  endtask

  // Hang guard, well above the sequences below
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    reset_n <= 1'b1;
    // Full chain read, first wait, slow flash, interrupt on
    slow   <= 1'b1;
    irq_en <= 1'b1;
    base = p.seq_byte;
    issue('{8'hC2, 8'hC1, 8'hC0, 1'b1, 1'b1, 6'h12},
          '{8'hC3, 3'h1, 3'h2, 3'h2, 3'h0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0,
            1'b1, 1'b0, 1'b0});
    check("busy", 16'h0001, {15'h0, busy});
    finish_seq();
    cmp_log('{9'h1C0, 9'h012, 9'h056, 9'h067, 9'h1C1, 9'h09A, 9'h0BC,
              9'h1C2, 9'h1C3});
    check("irq", 16'h0001, {15'h0, irq_seen});
    check("n_data", 16'h0003, 16'(p.n_data));
    check("data_reg", {8'h00, base + 8'h02}, {8'h00, data_reg});
    check("to_reg", 16'h0001, {15'h0, data_to_reg});
    check("dir", 16'h0000, {15'h0, data_write});
    check("in_sel", 16'h0001, {15'h0, input_sel});
    // Write with final wait, prompt flash, interrupt off
    slow      <= 1'b0;
    irq_en    <= 1'b0;
    data_size <= 16'h0002;
    issue('{8'h00, 8'h00, 8'hD5, 1'b0, 1'b0, 6'h13},
          '{8'h00, 3'h0, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1,
            1'b1, 1'b0, 1'b0});
    finish_seq();
    cmp_log('{9'h1D5});
    check("rdy_done", 16'h0001, {15'h0, rdy});
    check("irq_off", 16'h0000, {15'h0, irq_seen});
    check("n_data", 16'h0005, 16'(p.n_data));
    check("dir", 16'h0001, {15'h0, data_write});
    // Reset sequence forces the reset opcode, selects zeroed
    issue('{8'h00, 8'h00, 8'h90, 1'b1, 1'b1, 6'h00}, '0);
    finish_seq();
    cmp_log('{9'h1FF});
    check("in_sel", 16'h0000, {15'h0, input_sel});
    check("to_reg", 16'h0000, {15'h0, data_to_reg});
    // Busy flash: plain opcode refused, status read runs at once
    slow      <= 1'b1;
    data_size <= 16'h0001;
    issue('{8'hC2, 8'hC1, 8'hC0, 1'b0, 1'b0, 6'h12},
          '{8'hC3, 3'h2, 3'h3, 3'h0, 3'h0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
            1'b0, 1'b0, 1'b0});
    issue('{8'h00, 8'h00, 8'h80, 1'b1, 1'b0, 6'h12},
          '{8'h00, 3'h0, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
            1'b1, 1'b1, 1'b0});
    check("refused", 16'h0001, {15'h0, refd});
    issue('{8'h00, 8'h00, 8'h70, 1'b1, 1'b0, 6'h12},
          '{8'h00, 3'h0, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
            1'b1, 1'b1, 1'b0});
    check("taken", 16'h0000, {15'h0, refd});
    finish_seq();
    check("to_reg", 16'h0001, {15'h0, data_to_reg});
    check("log_last", 16'h0170, {7'h00, p.log_q[$]});
    p.log_q.delete();
    // Identify with polled first wait; zero command gap
    slow      <= 1'b0;
    col0      <= 16'h3400;
    dly0      <= 16'h0000;
    data_size <= 16'h0005;
    nd = p.n_data - p.n_stat;
    issue('{8'h00, 8'h00, 8'h90, 1'b0, 1'b1, 6'h12},
          '{8'h00, 3'h1, 3'h0, 3'h0, 3'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0,
            1'b1, 1'b0, 1'b1});
    finish_seq();
    cmp_log('{9'h190, 9'h000, 9'h170});
    check("rdy_poll", 16'h0001, {15'h0, rdy});
    check("id_bytes", 16'(p.id_len),
          16'(p.n_data - p.n_stat - nd));
    close_out();
  end
endmodule
